// ### verilog/adcsc_pkg.sv
// shared constants and types of the converter sequencer control block
package adcsc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_CTRL    = 8'h10;
  localparam logic [7:0] IDX_CLK_FLAG_LOW = 8'h11;
  localparam logic [7:0] IDX_RESULT_HIGH  = 8'h12;
  localparam logic [7:0] IDX_REF_SELECT   = 8'h13;
  localparam logic [7:0] IDX_SAMPLE_RES   = 8'h14;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h18;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h19;

  // conv_mode_ctrl fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_START_BIT  = 6;
  localparam int MODE_EOC_BIT    = 5;
  localparam int MODE_GATE_BIT   = 4;
  localparam int MODE_CHAN_LSB   = 0;
  localparam int CHAN_W          = 4;
  // conv_clock_flag_low_result fields
  localparam int CLK_FLAG_BIT    = 7;
  localparam int CLK_IRQ_EN_BIT  = 6;
  localparam int CLK_DIV_LSB     = 4;
  localparam int CLK_LOW_LSB     = 0;
  // conv_reference_select fields
  localparam int REF_EXT_BIT     = 7;
  localparam int REF_LEVEL_LSB   = 0;
  // conv_sample_resolution fields
  localparam int SR_PB_LSB       = 4;
  localparam int SR_SAMPLE_LSB   = 2;
  localparam int SR_RES_LSB      = 0;
  // own irq status and mask: bit 0 is conversion complete
  localparam int IRQ_DONE_BIT    = 0;

  // reset values
  localparam logic [7:0] RST_MODE_CTRL  = 8'h20;
  localparam logic [7:0] RST_CLK_FLAG   = 8'h00;
  localparam logic [7:0] RST_REF_SELECT = 8'h03;
  localparam logic [7:0] RST_SAMPLE_RES = 8'h0A;
  localparam logic       RST_IRQ_MASK   = 1'b1;

  // channel codes
  localparam logic [3:0] CHAN_LAST_CODE = 4'hC;

  // divider codes
  localparam logic [1:0] DIV_CODE_16 = 2'h0;
  localparam logic [1:0] DIV_CODE_8  = 2'h1;
  localparam logic [1:0] DIV_CODE_1  = 2'h2;
  localparam logic [1:0] DIV_CODE_2  = 2'h3;
  localparam int         DIV_CNT_W   = 4;

  // resolution and sampling figures
  localparam logic [3:0] BITS_8  = 4'h8;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_12 = 4'hC;
  localparam int         RESULT_W = 12;
  localparam int         STEP_W   = 4;

  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  typedef enum logic [1:0] {REF_2V, REF_3V, REF_4V, REF_SUPPLY} adcsc_ref_level_type;

  // controls towards the analog core and pads
  typedef struct packed {
    logic                power;
    logic                connect;
    logic [CHAN_W-1:0]   channel;
    logic                ref_external;
    adcsc_ref_level_type ref_level;
    logic                sampling;
    logic                converting;
    logic                conv_clk;
    logic [1:0]          resolution;
    logic [3:0]          pb_analog_only;
  } adcsc_core_ctrl_type;

endpackage : adcsc_pkg

// ### verilog/adcsc_clk_div.sv
// converter clock tick generator derived from the instruction clock
`timescale 1ns/1ps
`default_nettype none
module adcsc_clk_div
  import adcsc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [1:0] i_div_code,
  output logic            o_tick
);

  logic [DIV_CNT_W-1:0] cnt_ff;
  logic [DIV_CNT_W-1:0] last;

  // terminal count of the divider for each code
  function automatic logic [DIV_CNT_W-1:0] div_last(input logic [1:0] code);
    case (code)
      DIV_CODE_16: div_last = 4'hF;
      DIV_CODE_8:  div_last = 4'h7;
      DIV_CODE_1:  div_last = 4'h0;
      DIV_CODE_2:  div_last = 4'h1;
      default:     div_last = 4'hF;
    endcase
  endfunction : div_last

  assign last = div_last(i_div_code);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !i_run || cnt_ff >= last)
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= i_run && (cnt_ff >= last);
    end
  end

endmodule : adcsc_clk_div
`default_nettype wire

// ### verilog/adcsc_top.sv
// converter sequencer control: registers, sequencer and core controls
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [APB_AW-1:0]   i_paddr,
  input  wire logic [APB_DW-1:0]   i_pwdata,
  output logic      [APB_DW-1:0]   o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  input  wire logic [RESULT_W-1:0] i_core_result,
  output adcsc_core_ctrl_type      o_core,
  output logic                     o_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcsc_state_type;

  // software state
  logic                enable_ff;
  logic                eoc_ff;
  logic                gate_ff;
  logic [CHAN_W-1:0]   chan_ff;
  logic                flag_ff;
  logic                irq_en_ff;
  logic [1:0]          div_ff;
  logic [RESULT_W-1:0] result_ff;
  logic                ref_ext_ff;
  logic [1:0]          ref_level_ff;
  logic [3:0]          pb_analog_ff;
  logic [1:0]          sample_ff;
  logic [1:0]          res_ff;
  logic                mask_ff;
  // sequencer
  adcsc_state_type     state_ff;
  adcsc_state_type     nxt_state;
  logic [STEP_W-1:0]   step_ff;
  logic [STEP_W-1:0]   nxt_step;
  logic                conv_tick;
  logic                done;
  logic                nxt_flag;
  // bus decode
  logic                setup;
  logic                wr_access;
  logic [7:0]          wr_idx;
  logic [7:0]          wr_byte;
  logic                wr_mode;
  logic                wr_clk_flag;
  logic                wr_ref;
  logic                wr_sample_res;
  logic                wr_irq_status;
  logic                wr_irq_mask;
  logic                start_ok;
  logic [7:0]          rd_value;
  logic                rd_hit;

  // register index from a byte address; off-word addresses never match
  function automatic logic [7:0] addr_index(input logic [APB_AW-1:0] addr);
    addr_index = (addr[1:0] == 2'h0) ? addr[9:2] : 8'hFF;
  endfunction : addr_index

  // number of converter clocks of the sampling phase, less one
  function automatic logic [STEP_W-1:0] sample_last(input logic [1:0] code);
    sample_last = (4'h1 << code) - 4'h1;
  endfunction : sample_last

  // number of bit steps, less one
  function automatic logic [STEP_W-1:0] bits_last(input logic [1:0] code);
    case (code)
      2'h0:    bits_last = BITS_8 - 4'h1;
      2'h1:    bits_last = BITS_10 - 4'h1;
      default: bits_last = BITS_12 - 4'h1;
    endcase
  endfunction : bits_last

  assign setup         = i_psel && !i_penable;
  assign wr_access     = i_psel && i_penable && i_pwrite && o_pready;
  assign wr_idx        = addr_index(i_paddr);
  assign wr_byte       = i_pwdata[7:0];
  assign wr_mode       = wr_access && (wr_idx == IDX_MODE_CTRL);
  assign wr_clk_flag   = wr_access && (wr_idx == IDX_CLK_FLAG_LOW);
  assign wr_ref        = wr_access && (wr_idx == IDX_REF_SELECT);
  assign wr_sample_res = wr_access && (wr_idx == IDX_SAMPLE_RES);
  assign wr_irq_status = wr_access && (wr_idx == IDX_IRQ_STATUS);
  assign wr_irq_mask   = wr_access && (wr_idx == IDX_IRQ_MASK);

  // the enable and gate being written take part in the decision
  assign start_ok = wr_mode && wr_byte[MODE_START_BIT] && wr_byte[MODE_ENABLE_BIT]
                    && wr_byte[MODE_GATE_BIT] && (state_ff == ST_IDLE);

  // mode register
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      enable_ff <= RST_MODE_CTRL[MODE_ENABLE_BIT];
      gate_ff   <= RST_MODE_CTRL[MODE_GATE_BIT];
      chan_ff   <= RST_MODE_CTRL[MODE_CHAN_LSB +: CHAN_W];
    end
    else if (wr_mode)
    begin
      enable_ff <= wr_byte[MODE_ENABLE_BIT];
      gate_ff   <= wr_byte[MODE_GATE_BIT];
      chan_ff   <= wr_byte[MODE_CHAN_LSB +: CHAN_W];
    end
  end

  // end-of-conversion status
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      eoc_ff <= RST_MODE_CTRL[MODE_EOC_BIT];
    end
    else
    begin
      eoc_ff <= done || ((state_ff == ST_IDLE) ? !start_ok : eoc_ff);
    end
  end

  // clock select and interrupt enable
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      irq_en_ff <= RST_CLK_FLAG[CLK_IRQ_EN_BIT];
      div_ff    <= RST_CLK_FLAG[CLK_DIV_LSB +: 2];
    end
    else if (wr_clk_flag)
    begin
      irq_en_ff <= wr_byte[CLK_IRQ_EN_BIT];
      div_ff    <= wr_byte[CLK_DIV_LSB +: 2];
    end
  end

  // completion flag: set wins over either clear path
  assign nxt_flag = done || (flag_ff
                    && !(wr_clk_flag && !wr_byte[CLK_FLAG_BIT])
                    && !(wr_irq_status && wr_byte[IRQ_DONE_BIT]));

  // completion flag, mask and the level request
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      flag_ff <= RST_CLK_FLAG[CLK_FLAG_BIT];
      mask_ff <= RST_IRQ_MASK;
      o_irq   <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      o_irq   <= nxt_flag && irq_en_ff && mask_ff;
      if (wr_irq_mask)
      begin
        mask_ff <= wr_byte[IRQ_DONE_BIT];
      end
    end
  end

  // reference, sampling, resolution and analog-only controls
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ref_ext_ff   <= RST_REF_SELECT[REF_EXT_BIT];
      ref_level_ff <= RST_REF_SELECT[REF_LEVEL_LSB +: 2];
    end
    else if (wr_ref)
    begin
      ref_ext_ff   <= wr_byte[REF_EXT_BIT];
      ref_level_ff <= wr_byte[REF_LEVEL_LSB +: 2];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      pb_analog_ff <= RST_SAMPLE_RES[SR_PB_LSB +: 4];
      sample_ff    <= RST_SAMPLE_RES[SR_SAMPLE_LSB +: 2];
      res_ff       <= RST_SAMPLE_RES[SR_RES_LSB +: 2];
    end
    else if (wr_sample_res)
    begin
      pb_analog_ff <= wr_byte[SR_PB_LSB +: 4];
      sample_ff    <= wr_byte[SR_SAMPLE_LSB +: 2];
      res_ff       <= wr_byte[SR_RES_LSB +: 2];
    end
  end

  adcsc_clk_div u_clk_div (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (state_ff != ST_IDLE),
    .i_div_code (div_ff),
    .o_tick     (conv_tick)
  );

  // sequencer: sample phase, then one step per result bit
  always_comb
  begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    done      = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_state = start_ok ? ST_SAMPLE : ST_IDLE;
      end
      ST_SAMPLE:
      begin
        if (conv_tick && step_ff >= sample_last(sample_ff))
        begin
          nxt_state = ST_CONVERT;
          nxt_step  = '0;
        end
        else if (conv_tick)
        begin
          nxt_step = step_ff + 4'h1;
        end
      end
      ST_CONVERT:
      begin
        if (conv_tick && step_ff >= bits_last(res_ff))
        begin
          nxt_state = ST_IDLE;
          nxt_step  = '0;
          done      = 1'b1;
        end
        else if (conv_tick)
        begin
          nxt_step = step_ff + 4'h1;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_step  = '0;
      end
    endcase
    // a disable or closed gate aborts without a result
    if ((!enable_ff || !gate_ff) && (state_ff != ST_IDLE))
    begin
      nxt_state = ST_IDLE;
      nxt_step  = '0;
      done      = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_IDLE;
      step_ff  <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      step_ff  <= nxt_step;
    end
  end

  // result latched with status and flag
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      result_ff <= '0;
    end
    else if (done)
    begin
      result_ff <= i_core_result;
    end
  end

  // read mux
  always_comb
  begin
    rd_value = 8'h00;
    rd_hit   = 1'b1;
    case (addr_index(i_paddr))
      IDX_MODE_CTRL:    rd_value = {enable_ff, 1'b0, eoc_ff, gate_ff, chan_ff};
      IDX_CLK_FLAG_LOW: rd_value = {flag_ff, irq_en_ff, div_ff, result_ff[3:0]};
      IDX_RESULT_HIGH:  rd_value = result_ff[11:4];
      IDX_REF_SELECT:   rd_value = {ref_ext_ff, 5'h00, ref_level_ff};
      IDX_SAMPLE_RES:   rd_value = {pb_analog_ff, sample_ff, res_ff};
      IDX_IRQ_STATUS:   rd_value = {7'h00, flag_ff};
      IDX_IRQ_MASK:     rd_value = {7'h00, mask_ff};
      default:          rd_hit   = 1'b0;
    endcase
  end

  // apb answer is prepared in the setup cycle, so access needs no wait
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= 1'b1;
      if (setup)
      begin
        o_prdata  <= i_pwrite ? '0 : {24'h000000, rd_value};
        o_pslverr <= !rd_hit;
      end
    end
  end

  // core and pad controls, all registered
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_core <= '0;
    end
    else
    begin
      o_core.power          <= enable_ff;
      o_core.connect        <= enable_ff && gate_ff && (chan_ff <= CHAN_LAST_CODE);
      o_core.channel        <= chan_ff;
      o_core.ref_external   <= ref_ext_ff;
      o_core.ref_level      <= adcsc_ref_level_type'(ref_level_ff);
      // busy shown only once power and gate are up, never ahead of them
      o_core.sampling       <= (nxt_state == ST_SAMPLE) && enable_ff && gate_ff;
      o_core.converting     <= (nxt_state == ST_CONVERT) && enable_ff && gate_ff;
      o_core.conv_clk       <= conv_tick;
      o_core.resolution     <= res_ff;
      o_core.pb_analog_only <= pb_analog_ff;
    end
  end

endmodule : adcsc_top
`default_nettype wire

// ### bench/adcsc_checker.sv
// port assertions of the converter sequencer control block
`timescale 1ns/1ps
`default_nettype none
module adcsc_checker
  import adcsc_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [APB_AW-1:0]   i_paddr,
  input  wire logic [APB_DW-1:0]   i_pwdata,
  input  wire logic [APB_DW-1:0]   o_prdata,
  input  wire logic                o_pready,
  input  wire adcsc_core_ctrl_type o_core,
  input  wire logic                o_irq
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_wr;
    i_psel && i_penable && i_pwrite && o_pready;
  endsequence
  sequence s_start;
    s_wr ##0 (i_paddr == 12'h040) && (i_pwdata[7:4] == 4'hD)
      && !o_core.sampling && !o_core.converting;
  endsequence
  property p_ready_up;
    i_rst_n |=> o_pready;
  endproperty
  a_ready_up: assert property (p_ready_up) else $error("pready low after reset");
  sequence s_idle;
    !o_core.sampling && !o_core.converting;
  endsequence
  property p_start_samples;
    s_start |=> ##1 (o_core.sampling && o_core.power);
  endproperty
  a_start_samples: assert property (p_start_samples) else $error("start not taken");
  property p_busy_power;
    (o_core.sampling || o_core.converting) |-> o_core.power;
  endproperty
  a_busy_power: assert property (p_busy_power) else $error("busy while unpowered");
  property p_conn_power;
    o_core.connect |-> o_core.power;
  endproperty
  a_conn_power: assert property (p_conn_power) else $error("connect while off");
  property p_conn_code;
    o_core.connect |-> o_core.channel <= CHAN_LAST_CODE;
  endproperty
  a_conn_code: assert property (p_conn_code) else $error("bad channel connected");
  property p_hi_zero;
    o_prdata[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read data set");
  property p_irq_cause;
    $rose(o_irq) |-> $past(o_core.converting) || $past(i_psel) || $past(i_psel, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_core_reset;
    $rose(i_rst_n) |-> (o_core == '0) && !o_irq;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("core not idle in reset");
  property p_clk_idle;
    s_idle [*3] |-> !o_core.conv_clk;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("converter clock while idle");
endmodule : adcsc_checker
`default_nettype wire

// ### bench/adcsc_core_model.sv
// analog core model: answers with a channel-dependent result word
`timescale 1ns/1ps
`default_nettype none
module adcsc_core_model
  import adcsc_pkg::*;
#(
  parameter logic [RESULT_W-1:0] BASE = 12'hA53
)
(
  input  wire logic                i_sys_clk,
  input  wire adcsc_core_ctrl_type i_core,
  output var logic [RESULT_W-1:0]  o_result
);
  initial o_result = '0;
  // outside a conversion the word toggles so a stale sample shows
  always @(posedge i_sys_clk)
  begin
    if (i_core.converting)
      o_result <= BASE ^ {8'h00, i_core.channel};
    else
      o_result <= ~o_result;
  end
endmodule : adcsc_core_model
`default_nettype wire

// ### bench/adcsc_top_tb.sv
// self-checking bench of the converter sequencer control block
`timescale 1ns/1ps
`default_nettype none
module adcsc_top_tb
  import adcsc_pkg::*;
;
  localparam logic [11:0] BASE = 12'hA53;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [APB_AW-1:0]   paddr = '0;
  logic [APB_DW-1:0]   pwdata = '0;
  logic [APB_DW-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic [RESULT_W-1:0] core_res;
  adcsc_core_ctrl_type core;
  logic                irq;
  int                  miscompares = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  logic [7:0]          q;
  logic                e;

  adcsc_top u_adcsc_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_core_result(core_res), .o_core(core), .o_irq(irq));
  adcsc_core_model #(.BASE(BASE)) u_adcsc_core_model (.i_sys_clk(clk), .i_core(core),
    .o_result(core_res));

  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic fail(input string m);
    miscompares++;
    $display("mismatch %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp)
      fail(m);
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                     output logic [7:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge clk);
    if (n == 20)
    begin
      fail("apb hang");
      give_verdict();
    end
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] ix, input logic [7:0] exp, input string m);
    apb(1'b0, ix, 8'h00, q, e);
    chk(q, exp, m);
  endtask : rdc
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic irqc(input logic exp);
    settle();
    chk({7'h0, irq}, {7'h0, exp}, "irq");
  endtask : irqc

  task automatic t_reset;
    logic [7:0] ix [7] = '{IDX_MODE_CTRL, IDX_CLK_FLAG_LOW, IDX_RESULT_HIGH,
                           IDX_REF_SELECT, IDX_SAMPLE_RES, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    logic [7:0] ex [7] = '{8'h20, 8'h00, 8'h00, 8'h03, 8'h0A, 8'h00, 8'h01};
    for (int i = 0; i < 7; i++)
      rdc(ix[i], ex[i], "reset value");
    apb(1'b0, 8'h15, 8'h00, q, e);
    chk({7'h0, e}, 8'h01, "unmapped error");
    chk(q, 8'h00, "unmapped data");
  endtask : t_reset

  task automatic t_regs;
    wr(IDX_REF_SELECT, 8'h82);
    rdc(IDX_REF_SELECT, 8'h82, "ref reg");
    chk({5'h0, core.ref_external, core.ref_level}, 8'h06, "ref out");
    wr(IDX_SAMPLE_RES, 8'hF5);
    rdc(IDX_SAMPLE_RES, 8'hF5, "sample reg");
    chk({core.pb_analog_only, 2'h0, core.resolution}, 8'hF1, "pads");
    wr(IDX_MODE_CTRL, 8'h9C);
    rdc(IDX_MODE_CTRL, 8'hBC, "mode reg");
    chk({core.power, core.connect, 2'h0, core.channel}, 8'hCC, "connect");
    wr(IDX_MODE_CTRL, 8'h9D);
    settle();
    chk({7'h0, core.connect}, 8'h00, "bad code");
    wr(IDX_MODE_CTRL, 8'h8C);
    settle();
    chk({7'h0, core.connect}, 8'h00, "gate off");
    wr(IDX_MODE_CTRL, 8'h1C);
    settle();
    chk({6'h0, core.power, core.connect}, 8'h00, "power off");
  endtask : t_regs

  task automatic t_conv(input logic [1:0] dv, input logic [1:0] sm, input logic [1:0] rs,
                        input logic [3:0] ch, input int nd);
    int n;
    int c0;
    logic [11:0] ex;
    ex = BASE ^ {8'h00, ch};
    wr(IDX_SAMPLE_RES, {4'h0, sm, rs});
    wr(IDX_CLK_FLAG_LOW, {2'b01, dv, 4'h0});
    wr(IDX_MODE_CTRL, {4'hD, ch});
    @(negedge clk);
    c0 = cyc;
    rdc(IDX_MODE_CTRL, {4'h9, ch}, "busy mode");
    chk({core.connect, core.channel, 1'b0, core.resolution}, {1'b1, ch, 1'b0, rs}, "core");
    for (n = 0; irq !== 1'b1 && n < 400; n++) @(negedge clk);
    if (n == 400)
    begin
      fail("no completion");
      give_verdict();
    end
    n = cyc - c0;
    n_compared++;
    if (n < nd || n > nd + 2)
      fail("conversion length");
    rdc(IDX_CLK_FLAG_LOW, {2'b11, dv, ex[3:0]}, "flag and low");
    rdc(IDX_RESULT_HIGH, ex[11:4], "high byte");
    rdc(IDX_MODE_CTRL, {4'hB, ch}, "done mode");
    wr(IDX_CLK_FLAG_LOW, {2'b01, dv, 4'h0});
    irqc(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h00, "flag cleared");
  endtask : t_conv

  task automatic t_irq;
    int n;
    wr(IDX_CLK_FLAG_LOW, 8'h20);
    wr(IDX_MODE_CTRL, 8'hD3);
    @(negedge clk);
    for (n = 0; (core.sampling || core.converting) && n < 100; n++) @(negedge clk);
    if (n == 100)
    begin
      fail("conversion hang");
      give_verdict();
    end
    irqc(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h01, "flag set");
    wr(IDX_CLK_FLAG_LOW, 8'hE0);
    irqc(1'b1);
    wr(IDX_IRQ_MASK, 8'h00);
    irqc(1'b0);
    wr(IDX_IRQ_MASK, 8'h01);
    irqc(1'b1);
    wr(IDX_IRQ_STATUS, 8'h01);
    irqc(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h00, "status cleared");
  endtask : t_irq

  task automatic t_refuse;
    wr(IDX_MODE_CTRL, 8'hC3);
    repeat (30) @(negedge clk);
    rdc(IDX_MODE_CTRL, 8'hA3, "gated start");
    wr(IDX_MODE_CTRL, 8'h53);
    repeat (30) @(negedge clk);
    rdc(IDX_MODE_CTRL, 8'h33, "disabled start");
    wr(IDX_MODE_CTRL, 8'hD3);
    wr(IDX_MODE_CTRL, 8'h13);
    repeat (30) @(negedge clk);
    rdc(IDX_MODE_CTRL, 8'h33, "aborted");
    rdc(IDX_IRQ_STATUS, 8'h00, "no flag");
  endtask : t_refuse

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_conv(2'h0, 2'h0, 2'h0, 4'h0, 144);
    t_conv(2'h1, 2'h1, 2'h1, 4'h5, 96);
    t_conv(2'h2, 2'h2, 2'h2, 4'hB, 16);
    t_conv(2'h3, 2'h3, 2'h3, 4'hC, 40);
    t_irq();
    t_refuse();
    give_verdict();
  end
endmodule : adcsc_top_tb

bind adcsc_top adcsc_checker u_adcsc_checker (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_core, .o_irq);
`default_nettype wire
